// ==== common/ufb_pkg.sv ====
// Shared constants, types and functions of the frame and baud configuration block.
`default_nettype none
package ufb_pkg;
   localparam logic [3:0] ADDR_DATA = 4'h0;
   localparam logic [3:0] ADDR_LSC = 4'h1;
   localparam logic [3:0] ADDR_ENC = 4'h2;
   localparam logic [3:0] ADDR_SHARED = 4'h3;
   localparam logic [3:0] ADDR_BAUD_LO = 4'h4;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;
   localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;
   localparam logic [3:0] ADDR_BAUD_HI_RD = 4'h7;
   localparam int FMT_SEL_BIT = 7;
   localparam int LSC_RXFULL = 7;
   localparam int LSC_TXRDY = 5;
   localparam int LSC_FE = 4;
   localparam int LSC_PE = 2;
   localparam int LSC_DBL = 1;
   localparam int ENC_RXEN = 4;
   localparam int ENC_TXEN = 3;
   localparam int ENC_CSZTOP = 2;
   localparam int ENC_RXB8 = 1;
   localparam int ENC_TXB8 = 0;
   localparam int IRQ_TXDONE = 0;
   localparam int IRQ_RXDONE = 1;
   localparam int IRQ_PE = 2;
   localparam int IRQ_FE = 3;
   localparam int IRQ_W = 4;
   localparam int BAUD_HI_W = 4;
   localparam int BAUD_W = 12;
   localparam int FRAME_W = 13;
   localparam logic [7:0] FMT_RESET = 8'h06;
   localparam logic [BAUD_W-1:0] BAUD_RESET = 12'h000;
   localparam logic [4:0] OVS_NORMAL = 5'h10;
   localparam logic [4:0] OVS_DOUBLE = 5'h08;

   typedef struct packed {
      logic sel;
      logic sync;
      logic [1:0] parity;
      logic stop2;
      logic [1:0] csz;
      logic pol;
   } ufb_fmt_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } ufb_bus_req_t;

   typedef enum logic {RX_IDLE, RX_DATA} ufb_rx_state_t;

   // Reserved size codes fall back to eight bits so a frame is always well formed.
   function automatic logic [3:0] ufb_char_len(input logic [2:0] code);
      case (code)
         3'b000: ufb_char_len = 4'd5;
         3'b001: ufb_char_len = 4'd6;
         3'b010: ufb_char_len = 4'd7;
         3'b111: ufb_char_len = 4'd9;
         default: ufb_char_len = 4'd8;
      endcase
   endfunction : ufb_char_len

   function automatic logic [8:0] ufb_mask(input logic [3:0] n);
      ufb_mask = 9'h1ff >> (4'd9 - n);
   endfunction : ufb_mask

   function automatic logic ufb_parity(input logic [8:0] d, input logic [3:0] n, input logic odd);
      ufb_parity = (^(d & ufb_mask(n))) ^ odd;
   endfunction : ufb_parity
endpackage : ufb_pkg
`default_nettype wire

// ==== hdl/ufb_sync_in.sv ====
// Two-stage synchroniser for an asynchronous input pin.
`timescale 1ns/1ps
`default_nettype none
module ufb_sync_in #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic pin,
   output logic sync_ff
);
   logic meta_ff;

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         meta_ff <= RESET_VAL;
         sync_ff <= RESET_VAL;
      end
      else
      begin
         meta_ff <= pin;
         sync_ff <= meta_ff;
      end
   end
endmodule : ufb_sync_in
`default_nettype wire

// ==== hdl/ufb_baud_gen.sv ====
// Baud prescaler: down counter giving one tick per divisor plus one clocks.
`timescale 1ns/1ps
`default_nettype none
module ufb_baud_gen #(
   parameter int DIV_W = 12
) (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [DIV_W-1:0] divisor,
   input wire logic [DIV_W-1:0] load_value,
   output logic tick_ff
);
   logic [DIV_W-1:0] cnt_ff;

   if (DIV_W < 1)
   begin : g_chk
      $error("DIV_W must be at least one");
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end
      else if (load)
      begin
         cnt_ff <= load_value;
         tick_ff <= 1'b0;
      end
      else if (cnt_ff == '0)
      begin
         cnt_ff <= divisor;
         tick_ff <= 1'b1;
      end
      else
      begin
         cnt_ff <= cnt_ff - 1'b1;
         tick_ff <= 1'b0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   reload_now_a:
   assert property (load |=> cnt_ff == $past(load_value) && !tick_ff)
      else $error("prescaler not reloaded by low divisor write");
   tick_period_a:
   assert property (cnt_ff == '0 && !load |=> tick_ff && cnt_ff == $past(divisor))
      else $error("prescaler tick missing after countdown");
endmodule : ufb_baud_gen
`default_nettype wire

// ==== hdl/ufb_top.sv ====
// Serial transceiver with frame format and baud divisor configuration registers.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module ufb_top (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire ufb_pkg::ufb_bus_req_t bus_req,
   output logic [7:0] rd_data_ff,
   input wire logic rxd_pin,
   output logic txd_ff,
   output logic sync_serial_clock_ff,
   output logic sync_serial_clock_oe_ff,
   output logic irq_ff
);
   import ufb_pkg::*;

   // -----------------------------------------------------------------
   // Configuration registers
   // -----------------------------------------------------------------
   ufb_fmt_t fmt_ff;
   logic [BAUD_HI_W-1:0] baud_hi_ff;
   logic [7:0] baud_lo_ff;
   logic dbl_ff;
   logic rx_en_ff;
   logic tx_en_ff;
   logic csz_top_ff;
   logic tx_b8_ff;
   logic [IRQ_W-1:0] irq_stat_ff;
   logic [IRQ_W-1:0] irq_mask_ff;
   logic wr_shared;
   logic wr_fmt;
   logic wr_hi;
   logic wr_lo;
   logic wr_data;
   logic rd_rxdata;

   always_comb
   begin
      wr_shared = bus_req.wr && bus_req.addr == ADDR_SHARED;
      wr_fmt = wr_shared && bus_req.wdata[FMT_SEL_BIT];
      wr_hi = wr_shared && !bus_req.wdata[FMT_SEL_BIT];
      wr_lo = bus_req.wr && bus_req.addr == ADDR_BAUD_LO;
      wr_data = bus_req.wr && bus_req.addr == ADDR_DATA;
      rd_rxdata = bus_req.rd && bus_req.addr == ADDR_DATA;
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         fmt_ff <= FMT_RESET;
      else if (wr_fmt)
         fmt_ff <= bus_req.wdata;
   end

   // Reserved upper bits are dropped, so stray ones cannot reach the divisor.
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         baud_hi_ff <= BAUD_RESET[BAUD_W-1:8];
         baud_lo_ff <= BAUD_RESET[7:0];
      end
      else
      begin
         if (wr_hi)
            baud_hi_ff <= bus_req.wdata[BAUD_HI_W-1:0];
         if (wr_lo)
            baud_lo_ff <= bus_req.wdata;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         dbl_ff <= 1'b0;
         rx_en_ff <= 1'b0;
         tx_en_ff <= 1'b0;
         csz_top_ff <= 1'b0;
         tx_b8_ff <= 1'b0;
         irq_mask_ff <= '0;
      end
      else
      begin
         if (bus_req.wr && bus_req.addr == ADDR_LSC)
            dbl_ff <= bus_req.wdata[LSC_DBL];
         if (bus_req.wr && bus_req.addr == ADDR_ENC)
         begin
            rx_en_ff <= bus_req.wdata[ENC_RXEN];
            tx_en_ff <= bus_req.wdata[ENC_TXEN];
            csz_top_ff <= bus_req.wdata[ENC_CSZTOP];
            tx_b8_ff <= bus_req.wdata[ENC_TXB8];
         end
         if (bus_req.wr && bus_req.addr == ADDR_IRQ_MASK)
            irq_mask_ff <= bus_req.wdata[IRQ_W-1:0];
      end
   end

   // -----------------------------------------------------------------
   // Frame format decode and bit timing
   // -----------------------------------------------------------------
   logic [3:0] n;
   logic par_en;
   logic tick;
   logic [4:0] ovs_lim;
   logic [4:0] tx_ovs_ff;
   logic rise;
   logic fall;
   logic chg_edge;
   logic smp_edge;
   logic tx_bit;

   always_comb
   begin
      n = ufb_char_len({csz_top_ff, fmt_ff.csz});
      par_en = fmt_ff.parity[1];
      ovs_lim = (dbl_ff && !fmt_ff.sync) ? OVS_DOUBLE : OVS_NORMAL;
      rise = tick && fmt_ff.sync && !sync_serial_clock_ff;
      fall = tick && fmt_ff.sync && sync_serial_clock_ff;
      chg_edge = fmt_ff.pol ? fall : rise;
      smp_edge = fmt_ff.pol ? rise : fall;
      tx_bit = fmt_ff.sync ? chg_edge : (tick && tx_ovs_ff >= ovs_lim - 5'd1);
   end

   ufb_baud_gen #(
      .DIV_W(BAUD_W)
   ) ufb_baud_gen_inst (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .load(wr_lo),
      .divisor({baud_hi_ff, baud_lo_ff}),
      .load_value({baud_hi_ff, bus_req.wdata}),
      .tick_ff(tick)
   );

   // A change of mode only restarts the bit divider; frames in flight are the caller's problem.
   always_ff @(posedge core_clk)
   begin
      if (!reset_n || fmt_ff.sync)
         tx_ovs_ff <= '0;
      else if (tick)
         tx_ovs_ff <= (tx_ovs_ff >= ovs_lim - 5'd1) ? 5'd0 : tx_ovs_ff + 5'd1;
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         sync_serial_clock_ff <= 1'b0;
         sync_serial_clock_oe_ff <= 1'b0;
      end
      else
      begin
         sync_serial_clock_oe_ff <= fmt_ff.sync;
         if (!fmt_ff.sync)
            sync_serial_clock_ff <= 1'b0;
         else if (tick)
            sync_serial_clock_ff <= !sync_serial_clock_ff;
      end
   end

   // -----------------------------------------------------------------
   // Transmitter
   // -----------------------------------------------------------------
   logic [8:0] tx_hold_ff;
   logic tx_pend_ff;
   logic [FRAME_W-2:0] tx_sh_ff;
   logic [3:0] tx_cnt_ff;
   logic tx_act_ff;
   logic [FRAME_W-1:0] tx_frame;
   logic [3:0] tx_len;
   logic tx_load;
   logic tx_done;

   always_comb
   begin
      tx_frame = '1;
      tx_frame[0] = 1'b0;
      for (int i = 0; i < 9; i++)
         if (4'(i) < n)
            tx_frame[i+1] = tx_hold_ff[i];
      if (par_en)
         tx_frame[n+4'd1] = ufb_parity(tx_hold_ff, n, fmt_ff.parity[0]);
      tx_len = 4'd2 + n + {3'b000, par_en} + {3'b000, fmt_ff.stop2};
      tx_load = tx_bit && tx_cnt_ff == 4'd0 && tx_pend_ff && tx_en_ff;
      tx_done = tx_bit && tx_cnt_ff == 4'd0 && tx_act_ff;
   end

   // Data written while the holding register is full is dropped.
   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         tx_pend_ff <= 1'b0;
         tx_hold_ff <= '0;
      end
      else if (wr_data && !tx_pend_ff)
      begin
         tx_pend_ff <= 1'b1;
         tx_hold_ff <= {tx_b8_ff, bus_req.wdata};
      end
      else if (tx_load)
         tx_pend_ff <= 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         txd_ff <= 1'b1;
         tx_sh_ff <= '1;
         tx_cnt_ff <= '0;
         tx_act_ff <= 1'b0;
      end
      else if (tx_load)
      begin
         txd_ff <= tx_frame[0];
         tx_sh_ff <= tx_frame[FRAME_W-1:1];
         tx_cnt_ff <= tx_len - 4'd1;
         tx_act_ff <= 1'b1;
      end
      else if (tx_bit && tx_cnt_ff != 4'd0)
      begin
         txd_ff <= tx_sh_ff[0];
         tx_sh_ff <= {1'b1, tx_sh_ff[FRAME_W-2:1]};
         tx_cnt_ff <= tx_cnt_ff - 4'd1;
      end
      else if (tx_done)
         tx_act_ff <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Receiver
   // -----------------------------------------------------------------
   logic rxd_s;
   ufb_rx_state_t rx_st_ff;
   logic [4:0] rx_phase_ff;
   logic [3:0] rx_cnt_ff;
   logic [FRAME_W-1:0] rx_sh_ff;
   logic [FRAME_W-1:0] rx_new;
   logic [FRAME_W-1:0] rx_al;
   logic [3:0] rx_k;
   logic [4:0] rx_target;
   logic rx_samp;
   logic rx_fin;
   logic [8:0] rx_word;
   logic perr;
   logic ferr;
   logic [8:0] rx_data_ff;
   logic rx_full_ff;
   logic pe_ff;
   logic fe_ff;

   ufb_sync_in #(
      .RESET_VAL(1'b1)
   ) ufb_sync_in_inst (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .pin(rxd_pin),
      .sync_ff(rxd_s)
   );

   // Only one stop bit is checked, whatever the transmit setting says.
   always_comb
   begin
      rx_target = (rx_st_ff == RX_DATA) ? ovs_lim - 5'd1 : (ovs_lim >> 1) - 5'd1;
      rx_samp = fmt_ff.sync ? smp_edge : (tick && rx_phase_ff == rx_target);
      rx_k = n + {3'b000, par_en} + 4'd1;
      rx_new = {rxd_s, rx_sh_ff[FRAME_W-1:1]};
      rx_al = rx_new >> (4'(FRAME_W) - rx_k);
      rx_word = rx_al[8:0] & ufb_mask(n);
      perr = par_en && rx_al[n] != ufb_parity(rx_word, n, fmt_ff.parity[0]);
      ferr = !rx_al[n + {3'b000, par_en}];
      rx_fin = rx_en_ff && rx_samp && rx_st_ff == RX_DATA && rx_cnt_ff == 4'd1;
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n || !rx_en_ff || fmt_ff.sync || rx_samp)
         rx_phase_ff <= '0;
      else if (rx_st_ff == RX_IDLE && rxd_s)
         rx_phase_ff <= '0;
      else if (tick)
         rx_phase_ff <= rx_phase_ff + 5'd1;
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n || !rx_en_ff)
      begin
         rx_st_ff <= RX_IDLE;
         rx_cnt_ff <= '0;
         rx_sh_ff <= '0;
      end
      else if (rx_samp)
      begin
         unique case (rx_st_ff)
            RX_IDLE:
            begin
               if (!rxd_s)
               begin
                  rx_st_ff <= RX_DATA;
                  rx_cnt_ff <= rx_k;
                  rx_sh_ff <= '0;
               end
            end
            RX_DATA:
            begin
               rx_sh_ff <= rx_new;
               rx_cnt_ff <= rx_cnt_ff - 4'd1;
               if (rx_cnt_ff == 4'd1)
                  rx_st_ff <= RX_IDLE;
            end
         endcase
      end
   end

   // A frame that ends in the cycle of a data read still lands; the new word wins.
   always_ff @(posedge core_clk)
   begin
      if (!reset_n || !rx_en_ff)
      begin
         rx_data_ff <= '0;
         rx_full_ff <= 1'b0;
         pe_ff <= 1'b0;
         fe_ff <= 1'b0;
      end
      else if (rx_fin)
      begin
         rx_data_ff <= rx_word;
         rx_full_ff <= 1'b1;
         pe_ff <= perr;
         fe_ff <= ferr;
      end
      else if (rd_rxdata)
      begin
         rx_full_ff <= 1'b0;
         pe_ff <= 1'b0;
         fe_ff <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Interrupts and read port
   // -----------------------------------------------------------------
   logic [IRQ_W-1:0] irq_set;
   logic [IRQ_W-1:0] irq_clr;
   logic [7:0] rdv;

   always_comb
   begin
      irq_set = '0;
      irq_set[IRQ_TXDONE] = tx_done;
      irq_set[IRQ_RXDONE] = rx_fin;
      irq_set[IRQ_PE] = rx_fin && perr;
      irq_set[IRQ_FE] = rx_fin && ferr;
      irq_clr = (bus_req.wr && bus_req.addr == ADDR_IRQ_STAT) ? bus_req.wdata[IRQ_W-1:0] : '0;
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
      begin
         irq_stat_ff <= '0;
         irq_ff <= 1'b0;
      end
      else
      begin
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   always_comb
   begin
      rdv = '0;
      case (bus_req.addr)
         ADDR_DATA: rdv = rx_data_ff[7:0];
         ADDR_LSC:
         begin
            rdv[LSC_RXFULL] = rx_full_ff;
            rdv[LSC_TXRDY] = !tx_pend_ff;
            rdv[LSC_FE] = fe_ff;
            rdv[LSC_PE] = pe_ff;
            rdv[LSC_DBL] = dbl_ff;
         end
         ADDR_ENC:
         begin
            rdv[ENC_RXEN] = rx_en_ff;
            rdv[ENC_TXEN] = tx_en_ff;
            rdv[ENC_CSZTOP] = csz_top_ff;
            rdv[ENC_RXB8] = rx_data_ff[8];
            rdv[ENC_TXB8] = tx_b8_ff;
         end
         ADDR_SHARED: rdv = {1'b1, fmt_ff[6:0]};
         ADDR_BAUD_HI_RD: rdv = {4'h0, baud_hi_ff};
         ADDR_BAUD_LO: rdv = baud_lo_ff;
         ADDR_IRQ_STAT: rdv[IRQ_W-1:0] = irq_stat_ff;
         ADDR_IRQ_MASK: rdv[IRQ_W-1:0] = irq_mask_ff;
         default: rdv = '0;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!reset_n)
         rd_data_ff <= '0;
      else
         rd_data_ff <= bus_req.rd ? rdv : 8'h00;
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sel_one_read_a:
   assert property (bus_req.rd && bus_req.addr == ADDR_SHARED |=> rd_data_ff[FMT_SEL_BIT])
      else $error("frame settings read without select bit");
   hi_write_route_a:
   assert property (wr_hi |=> $stable(fmt_ff) && baud_hi_ff == $past(bus_req.wdata[3:0]))
      else $error("select-low write did not reach baud high");
   hi_read_zero_a:
   assert property (bus_req.rd && bus_req.addr == ADDR_BAUD_HI_RD |=> !rd_data_ff[FMT_SEL_BIT])
      else $error("baud high read shows select bit");
   async_clock_off_a:
   assert property (!fmt_ff.sync [*2] |-> !sync_serial_clock_ff && !sync_serial_clock_oe_ff)
      else $error("serial clock driven in asynchronous mode");
   tx_parity_bit_a:
   assert property (tx_load && par_en |=> tx_sh_ff[$past(n)] ==
      ((^($past(tx_hold_ff) & ufb_mask($past(n)))) ^ $past(fmt_ff.parity[0])))
      else $error("transmitted parity bit wrong");
   rx_parity_flag_a:
   assert property (rx_fin && perr |=> pe_ff && irq_stat_ff[IRQ_PE])
      else $error("parity mismatch not flagged");
   stop_count_a:
   assert property (tx_load |=> tx_cnt_ff == 4'd1 + $past(n) + $past(par_en) + $past(fmt_ff.stop2))
      else $error("transmit frame length wrong");
   char_size_map_a:
   assert property ({csz_top_ff, fmt_ff.csz} == 3'b111 |-> n == 4'd9)
      else $error("nine-bit size code decoded wrongly");
   sync_tx_edge_a:
   assert property (fmt_ff.sync && $changed(txd_ff) |-> $changed(sync_serial_clock_ff)
      && sync_serial_clock_ff != $past(fmt_ff.pol))
      else $error("synchronous transmit data changed on wrong edge");
   dbl_speed_a:
   assert property (!fmt_ff.sync && dbl_ff && tick && tx_ovs_ff == OVS_DOUBLE - 5'd1 |-> tx_bit)
      else $error("double speed bit divider wrong");

   tx_parity_c: cover property (tx_load && par_en && fmt_ff.stop2);
   rx_perr_c: cover property (rx_fin && perr);
   sync_tx_c: cover property (tx_load && fmt_ff.sync && fmt_ff.pol);
   irq_raise_c: cover property (irq_ff);
endmodule : ufb_top
`default_nettype wire

// ==== bench/ufb_peer.sv ====
// Remote serial peer: samples transmitted frames and sends frames to the receiver.
`timescale 1ns/1ps
`default_nettype none
module ufb_peer (
   input wire logic core_clk,
   input wire logic txd,
   input wire logic listen,
   input wire logic [9:0] bit_clks,
   input wire logic [3:0] n_bits,
   output logic rxd,
   output logic cap_valid,
   output logic [11:0] cap_bits
);
   initial
   begin
      rxd = 1'b1;
      cap_valid = 1'b0;
      cap_bits = '1;
   end
   // Sampling mid-bit means a wrong bit time slips the point and corrupts later bits.
   always
   begin
      @(negedge txd);
      if (listen)
      begin
         cap_bits = '1;
         repeat (bit_clks / 2) @(posedge core_clk);
         for (int i = 0; i < n_bits; i++)
         begin
            repeat (bit_clks) @(posedge core_clk);
            cap_bits[i] = txd;
         end
         cap_valid <= 1'b1;
         @(posedge core_clk);
         cap_valid <= 1'b0;
      end
   end
   task automatic send(input logic [11:0] bits, input int n);
      rxd <= 1'b0;
      repeat (bit_clks) @(posedge core_clk);
      for (int i = 0; i < n; i++)
      begin
         rxd <= bits[i];
         repeat (bit_clks) @(posedge core_clk);
      end
      rxd <= 1'b1;
   endtask : send
endmodule : ufb_peer
`default_nettype wire

// ==== bench/uart_frame_and_baud_config_test.sv ====
// Self-checking bench for the frame and baud configuration block.
`timescale 1ns/1ps
`default_nettype none
module uart_frame_and_baud_config_test;
   import ufb_pkg::*;
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   ufb_bus_req_t bus_req = '0;
   logic [7:0] rd_data_ff;
   logic txd_ff, sclk, sclk_oe, irq_ff, rxd, cap_valid, txd_q, sclk_q;
   logic listen = 1'b0;
   logic rd_q = 1'b0;
   logic sync_chk = 1'b0;
   logic pol = 1'b0;
   logic [9:0] bit_clks = 10'd64;
   logic [3:0] n_bits = 4'd10;
   logic [11:0] cap_bits;
   logic [11:0] rq[$];
   logic [11:0] fq[$];
   int fail_count = 0;
   int n_compared = 0;
   int seed = 74;

   always #20 core_clk = ~core_clk;

   ufb_top ufb_top_inst (.core_clk(core_clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
      .rxd_pin(rxd), .txd_ff(txd_ff), .sync_serial_clock_ff(sclk), .sync_serial_clock_oe_ff(sclk_oe), .irq_ff(irq_ff));
   ufb_peer ufb_peer_inst (.core_clk(core_clk), .txd(txd_ff), .listen(listen), .bit_clks(bit_clks),
      .n_bits(n_bits), .rxd(rxd), .cap_valid(cap_valid), .cap_bits(cap_bits));

   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic give_verdict();
      if (fail_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict

   task automatic op(input logic w, input logic [3:0] a, input logic [7:0] d);
      bus_req <= '{wr: w, rd: !w, addr: a, wdata: w ? d : 8'h00};
      if (!w)
         rq.push_back({4'h0, d});
      @(posedge core_clk);
   endtask : op

   task automatic idle(input int n);
      bus_req <= '0;
      repeat (n) @(posedge core_clk);
   endtask : idle

   function automatic logic [11:0] frm(input logic [8:0] d, input int n, input logic [1:0] pm);
      logic [11:0] f;
      f = '1;
      for (int i = 0; i < n; i++)
         f[i] = d[i];
      if (pm[1])
         f[n] = (^(d & ((9'h001 << n) - 9'h001))) ^ pm[0];
      return f;
   endfunction : frm

   always @(posedge core_clk)
   begin
      if (rd_q)
         check("read data", rq.pop_front(), {4'h0, rd_data_ff});
      rd_q <= bus_req.rd;
      if (cap_valid)
         check("tx frame", fq.pop_front(), cap_bits);
      if (sync_chk && txd_ff !== txd_q)
         check("sync edge", 12'h001, {11'h0, pol ? (sclk_q && !sclk) : (sclk && !sclk_q)});
      txd_q <= txd_ff;
      sclk_q <= sclk;
   end

   initial
   begin
      repeat (40000) @(posedge core_clk);
      fail_count++;
      give_verdict();
   end

   initial
   begin
      logic [8:0] d;
      logic [2:0] code;
      logic [1:0] pm;
      logic stop;
      logic dbl;
      int len;
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      @(posedge core_clk);
      op(0, 4'h3, FMT_RESET | 8'h80);
      op(0, 4'h7, 8'h00);
      op(0, 4'h1, 8'h20);
      op(0, 4'h2, 8'h00);
      op(0, 4'h5, 8'h00);
      op(0, 4'h6, 8'h00);
      op(1, 4'h9, 8'h5A);
      op(0, 4'h9, 8'h00);
      op(1, 4'h3, 8'h0B);
      op(0, 4'h7, 8'h0B);
      op(1, 4'h7, 8'hFF);
      op(0, 4'h7, 8'h0B);
      op(0, 4'h3, 8'h86);
      op(1, 4'h3, 8'h00);
      op(1, 4'h4, 8'h03);
      listen <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         code = (i == 4) ? 3'b111 : 3'(i % 4);
         len = (code == 3'b111) ? 9 : code + 5;
         pm = 2'(i);
         stop = 1'($random(seed));
         d = 9'($random(seed));
         dbl = (i == 5);
         bit_clks <= dbl ? 10'd32 : 10'd64;
         n_bits <= 4'(len + pm[1] + 1 + stop);
         op(1, 4'h1, {6'h00, dbl, 1'b0});
         op(1, 4'h3, {2'b10, pm, stop, code[1:0], 1'b0});
         op(1, 4'h2, {3'h0, 2'b11, code[2], 1'b0, d[8]});
         op(1, 4'h0, d[7:0]);
         fq.push_back(frm(d, len, pm));
         idle(70);
         op(1, 4'h0, d[7:0]);
         fq.push_back(frm(d, len, pm));
         idle(1);
         for (int k = 0; k < 2000 && fq.size() > 0; k++)
            @(posedge core_clk);
         check("frames left", 12'h000, 12'(fq.size()));
         idle(128);
      end
      // The receiver is checked at the slower rate only; double speed is a transmit concern here.
      listen <= 1'b0;
      bit_clks <= 10'd64;
      op(1, 4'h1, 8'h00);
      op(1, 4'h3, 8'hA6);
      op(1, 4'h5, 8'h0F);
      op(1, 4'h6, 8'h02);
      for (int j = 0; j < 2; j++)
      begin
         d = 9'($random(seed));
         idle(1);
         ufb_peer_inst.send(frm({1'b0, d[7:0]}, 8, 2'b10) ^ {3'h0, j[0], 8'h00}, 10);
         idle(20);
         check("irq raised", 12'h001, {11'h0, irq_ff});
         op(0, 4'h1, {3'b101, 2'b00, j[0], 2'b00});
         op(0, 4'h5, {5'h00, j[0], 2'b10});
         op(0, 4'h0, d[7:0]);
         op(1, 4'h5, 8'h02);
         idle(3);
         check("irq masked", 12'h000, {11'h0, irq_ff});
         op(0, 4'h5, {5'h00, j[0], 2'b00});
         op(1, 4'h5, 8'h04);
      end
      for (int p = 0; p < 2; p++)
      begin
         pol <= p[0];
         op(1, 4'h3, {2'b11, 5'b00011, p[0]});
         op(1, 4'h0, 8'($random(seed)));
         idle(2);
         sync_chk <= 1'b1;
         check("clock enable", 12'h001, {11'h0, sclk_oe});
         idle(200);
         sync_chk <= 1'b0;
      end
      op(1, 4'h3, 8'h86);
      idle(3);
      check("clock idle", 12'h000, {10'h0, sclk_oe, sclk});
      idle(5);
      give_verdict();
   end
endmodule : uart_frame_and_baud_config_test
`default_nettype wire
